// file: include/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// Register byte offsets (printed offsets are not word multiples: index * 4)
`define ACS_IDX_CTRL 12'hf70
`define ACS_IDX_RES_HI 12'hf72
`define ACS_IDX_RES_LO 12'hf73
`define ACS_IDX_DMA 12'hf74
`define ACS_ADDR_CTRL 14'h3dc0
`define ACS_ADDR_RES_HI 14'h3dc8
`define ACS_ADDR_RES_LO 14'h3dcc
`define ACS_ADDR_DMA 14'h3dd0
// Control register fields and reset value
`define ACS_BIT_GO 7
`define ACS_BIT_RSVD 6
`define ACS_BIT_REF 5
`define ACS_BIT_REPEAT 4
`define ACS_CTRL_RESET 8'h20
`define ACS_SEL_RSVD 2'h3
// Timing figures in system clock cycles
`define ACS_IDLE_LIMIT 160
`define ACS_POWERUP 40
`define ACS_SINGLE 5129
`define ACS_REPEAT_INT 256
`endif

// file: include/acs_pkg.sv
package acs_pkg;
	typedef enum logic [1:0] {
		ACS_OFF = 2'b00,
		ACS_IDLE = 2'b01,
		ACS_WAKE = 2'b10,
		ACS_CONV = 2'b11
	} acs_state_t;
	// Control register image
	typedef struct packed {
		logic go;
		logic rsvd;
		logic ext_ref;
		logic repeat_sel;
		logic [3:0] input_select;
	} acs_ctrl_t;
	// Analog core control bundle
	typedef struct packed {
		logic powered;
		logic converting;
		logic int_ref_en;
		logic [3:0] input_select;
	} acs_analog_t;
endpackage

// file: hw/acs_sequencer.sv
`include "acs_cfg.svh"

module acs_sequencer #(
	parameter int SINGLE_CYCLES = `ACS_SINGLE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dma_start,
	input wire logic [3:0] dma_input_select,
	input wire logic [9:0] core_sample,
	output acs_pkg::acs_analog_t analog_ctl,
	output logic conv_irq
);
	localparam int IDLE_W = $clog2(`ACS_IDLE_LIMIT + 1);
	localparam int CNT_W = $clog2(SINGLE_CYCLES + `ACS_POWERUP + 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(`ACS_IDLE_LIMIT - 1);
	localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(`ACS_POWERUP - 1);
	localparam logic [CNT_W-1:0] SINGLE_LAST = CNT_W'(SINGLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] REPEAT_LAST = CNT_W'(`ACS_REPEAT_INT - 1);
	// Check-side limits: a full run from power-down, and a saturation ceiling
	localparam logic [CNT_W-1:0] FULL_LAST = CNT_W'(SINGLE_CYCLES + `ACS_POWERUP - 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(SINGLE_CYCLES + `ACS_POWERUP);

	acs_pkg::acs_state_t state_q;
	acs_pkg::acs_ctrl_t ctrl_q;
	logic [IDLE_W-1:0] idle_q;
	logic [CNT_W-1:0] cnt_q;
	logic first_done_q;
	logic [7:0] res_hi_q;
	logic [1:0] res_lo_new_q;
	logic [1:0] res_lo_q;
	logic [31:0] rdata_d;
	logic ack_q;
	logic bus_req;
	logic wr_ctrl;
	logic rd_hi;
	logic sw_start;
	logic start;
	logic done;
	logic [CNT_W-1:0] since_start_q;
	logic [CNT_W-1:0] since_done_q;
	logic from_off_q;

	// Requests are taken while ack is low; ack drops the cycle after it is given
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	// Writes land at the edge where the master sees ack, while address and data still stand
	assign wr_ctrl = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0] &
		(wb_adr_i[13:0] == `ACS_ADDR_CTRL);
	assign rd_hi = bus_req & ~wb_we_i & (wb_adr_i[13:0] == `ACS_ADDR_RES_HI);
	// Writing go as one starts; a zero written there is simply dropped
	assign sw_start = wr_ctrl & wb_dat_i[`ACS_BIT_GO];
	assign start = sw_start | dma_start;
	// Completion: single count ends, or repeat interval ends after the first
	assign done = (state_q == acs_pkg::ACS_CONV) & ~start &
		(first_done_q ? (cnt_q == REPEAT_LAST) : (cnt_q == SINGLE_LAST));

	// Control register; hardware clear of go yields to a new start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= acs_pkg::acs_ctrl_t'(`ACS_CTRL_RESET);
		end else begin
			if (wr_ctrl) begin
				ctrl_q.ext_ref <= wb_dat_i[`ACS_BIT_REF];
				ctrl_q.repeat_sel <= wb_dat_i[`ACS_BIT_REPEAT];
				ctrl_q.rsvd <= 1'b0;
				if (wb_dat_i[3:2] != `ACS_SEL_RSVD) begin
					ctrl_q.input_select <= wb_dat_i[3:0];
				end
			end
			if (dma_start) begin
				ctrl_q.input_select <= dma_input_select;
			end
			if (start) begin
				ctrl_q.go <= 1'b1;
			end else if (done && !first_done_q) begin
				ctrl_q.go <= 1'b0;
			end
		end
	end

	// Sequencer states: off, idle powered, waking, converting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= acs_pkg::ACS_OFF;
		end else begin
			case (state_q)
				acs_pkg::ACS_OFF: begin
					if (start) begin
						state_q <= acs_pkg::ACS_WAKE;
					end
				end
				acs_pkg::ACS_IDLE: begin
					if (start) begin
						state_q <= acs_pkg::ACS_CONV;
					end else if (idle_q == IDLE_LAST) begin
						state_q <= acs_pkg::ACS_OFF;
					end
				end
				acs_pkg::ACS_WAKE: begin
					if (!start && cnt_q == WAKE_LAST) begin
						state_q <= acs_pkg::ACS_CONV;
					end
				end
				acs_pkg::ACS_CONV: begin
					// Repeat select is sampled at each completion
					if (done && !ctrl_q.repeat_sel) begin
						state_q <= acs_pkg::ACS_IDLE;
					end
				end
				default: begin
					state_q <= acs_pkg::ACS_OFF;
				end
			endcase
		end
	end

	// Phase counter: restarts on start, phase change and each completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (start || done) begin
			cnt_q <= '0;
		end else if (state_q == acs_pkg::ACS_WAKE && cnt_q == WAKE_LAST) begin
			cnt_q <= '0;
		end else if (state_q == acs_pkg::ACS_WAKE || state_q == acs_pkg::ACS_CONV) begin
			cnt_q <= cnt_q + 1'b1;
		end else begin
			cnt_q <= '0;
		end
	end

	// First-result marker switches repeat mode to the short interval
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_done_q <= 1'b0;
		end else if (start || state_q != acs_pkg::ACS_CONV) begin
			first_done_q <= 1'b0;
		end else if (done) begin
			first_done_q <= ctrl_q.repeat_sel;
		end
	end

	// Idle counter only runs while powered with nothing to do
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_q <= '0;
		end else if (start || state_q != acs_pkg::ACS_IDLE) begin
			idle_q <= '0;
		end else begin
			idle_q <= idle_q + 1'b1;
		end
	end

	// Result capture; the low pair is staged until the high byte is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res_hi_q <= 8'h00;
			res_lo_new_q <= 2'h0;
			res_lo_q <= 2'h0;
		end else begin
			if (done) begin
				res_hi_q <= core_sample[9:2];
				res_lo_new_q <= core_sample[1:0];
			end
			if (rd_hi) begin
				res_lo_q <= res_lo_new_q;
			end
		end
	end

	// Completion interrupt pulse, registered so it lines up after the result
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_irq <= 1'b0;
		end else begin
			conv_irq <= done;
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (wb_adr_i[13:0] == `ACS_ADDR_CTRL) begin
			rdata_d[7:0] = ctrl_q;
		end else if (wb_adr_i[13:0] == `ACS_ADDR_RES_HI) begin
			rdata_d[7:0] = res_hi_q;
		end else if (wb_adr_i[13:0] == `ACS_ADDR_RES_LO) begin
			rdata_d[7:6] = res_lo_q;
		end else if (wb_adr_i[13:0] == `ACS_ADDR_DMA) begin
			rdata_d[1:0] = state_q;
		end
	end

	// Bus answer one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req;
			wb_dat_o <= bus_req ? rdata_d : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;

	// Analog side controls
	always_comb begin
		analog_ctl.powered = (state_q != acs_pkg::ACS_OFF);
		analog_ctl.converting = (state_q == acs_pkg::ACS_CONV);
		analog_ctl.int_ref_en = ~ctrl_q.ext_ref;
		analog_ctl.input_select = ctrl_q.input_select;
	end

	// Independent cycle count since the last start, kept apart from the phase counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_start_q <= '0;
			from_off_q <= 1'b0;
		end else if (start) begin
			since_start_q <= '0;
			from_off_q <= (state_q == acs_pkg::ACS_OFF) || (state_q == acs_pkg::ACS_WAKE);
		end else if (since_start_q != CNT_MAX) begin
			since_start_q <= since_start_q + 1'b1;
		end
	end

	// Cycles since the last completion, so the repeat interval is measured on its own
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_done_q <= '0;
		end else if (start || done) begin
			since_done_q <= '0;
		end else if (since_done_q != CNT_MAX) begin
			since_done_q <= since_done_q + 1'b1;
		end
	end

	// Checks; wake ends on its last count and conversion begins from zero
	sequence s_wake_end;
		state_q == acs_pkg::ACS_WAKE && cnt_q == WAKE_LAST && !start;
	endsequence

	sequence s_conv_begin;
		state_q == acs_pkg::ACS_CONV && cnt_q == '0;
	endsequence

	chk_idle_powerdown: assert property (@(posedge clk) disable iff (rst)
		(state_q == acs_pkg::ACS_IDLE && idle_q == IDLE_LAST && !start)
		|=> state_q == acs_pkg::ACS_OFF)
		else $error("idle limit did not power down");
	chk_off_wake: assert property (@(posedge clk) disable iff (rst)
		(state_q == acs_pkg::ACS_OFF && start) |=> state_q == acs_pkg::ACS_WAKE)
		else $error("request did not start power up");
	chk_wake_length: assert property (@(posedge clk) disable iff (rst)
		s_wake_end |=> s_conv_begin)
		else $error("power up time wrong");
	chk_single_count: assert property (@(posedge clk) disable iff (rst)
		(done && !first_done_q) |-> since_start_q == (from_off_q ? FULL_LAST : SINGLE_LAST))
		else $error("single count wrong");
	chk_go_clear: assert property (@(posedge clk) disable iff (rst)
		(done && !first_done_q) |=> !ctrl_q.go)
		else $error("go bit not cleared");
	chk_go_stays: assert property (@(posedge clk) disable iff (rst)
		(first_done_q && !start) |=> !ctrl_q.go)
		else $error("go set during repeat");
	chk_irq_done: assert property (@(posedge clk) disable iff (rst)
		done |=> conv_irq)
		else $error("interrupt not pulsed");
	chk_repeat_int: assert property (@(posedge clk) disable iff (rst)
		(done && first_done_q) |-> since_done_q == REPEAT_LAST)
		else $error("repeat interval wrong");
	chk_stop_repeat: assert property (@(posedge clk) disable iff (rst)
		(done && !ctrl_q.repeat_sel) |=> state_q == acs_pkg::ACS_IDLE)
		else $error("conversion did not stop");
	chk_result_write: assert property (@(posedge clk) disable iff (rst)
		done |=> res_hi_q == $past(core_sample[9:2]))
		else $error("result not written");
	chk_low_latch: assert property (@(posedge clk) disable iff (rst)
		rd_hi |=> res_lo_q == $past(res_lo_new_q))
		else $error("low bits not latched");
	chk_restart: assert property (@(posedge clk) disable iff (rst)
		(sw_start && state_q == acs_pkg::ACS_CONV) |=> cnt_q == '0 && ctrl_q.go)
		else $error("restart failed");

	// Interrupt only follows a completion
	chk_irq_quiet: assert property (@(posedge clk) disable iff (rst)
		!done |=> !conv_irq)
		else $error("interrupt without completion");

	// Wake never overruns its count
	chk_wake_bound: assert property (@(posedge clk) disable iff (rst)
		state_q == acs_pkg::ACS_WAKE |-> cnt_q <= WAKE_LAST)
		else $error("wake count overrun");

	// Without a request the converter stays powered down
	chk_off_stays: assert property (@(posedge clk) disable iff (rst)
		(state_q == acs_pkg::ACS_OFF && !start) |=> state_q == acs_pkg::ACS_OFF)
		else $error("woke without request");

	// A zero written to go leaves it alone
	chk_go_ignore: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && !wb_dat_i[`ACS_BIT_GO] && !dma_start && !done) |=> $stable(ctrl_q.go))
		else $error("go changed by zero write");

	// Go reads one through wake and the first conversion
	chk_go_busy: assert property (@(posedge clk) disable iff (rst)
		(state_q == acs_pkg::ACS_WAKE || (state_q == acs_pkg::ACS_CONV && !first_done_q))
		|-> ctrl_q.go)
		else $error("go low while busy");

	// DMA start loads its input select
	chk_dma_select: assert property (@(posedge clk) disable iff (rst)
		dma_start |=> ctrl_q.input_select == $past(dma_input_select))
		else $error("dma select not loaded");

	// Reserved select codes leave the field unchanged
	chk_sel_reserved: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && wb_dat_i[3:2] == `ACS_SEL_RSVD && !dma_start)
		|=> $stable(ctrl_q.input_select))
		else $error("reserved select taken");

	// Reference select follows the written bit
	chk_ref_field: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> ctrl_q.ext_ref == $past(wb_dat_i[`ACS_BIT_REF]))
		else $error("reference select not written");

	// Idle count clears whenever there is work
	chk_idle_clear: assert property (@(posedge clk) disable iff (rst)
		(start || state_q != acs_pkg::ACS_IDLE) |=> idle_q == '0)
		else $error("idle count not cleared");

	// Repeat mode keeps converting after a completion
	chk_repeat_keep: assert property (@(posedge clk) disable iff (rst)
		(done && ctrl_q.repeat_sel) |=> state_q == acs_pkg::ACS_CONV)
		else $error("repeat stopped early");

	// Result high byte changes only at completion
	chk_result_hold: assert property (@(posedge clk) disable iff (rst)
		!done |=> $stable(res_hi_q))
		else $error("result changed without completion");

	// Low pair changes only on a high byte read
	chk_low_hold: assert property (@(posedge clk) disable iff (rst)
		!rd_hi |=> $stable(res_lo_q))
		else $error("low bits changed without read");

	// A start during wake restarts the wake count
	chk_restart_wake: assert property (@(posedge clk) disable iff (rst)
		(start && state_q == acs_pkg::ACS_WAKE) |=> state_q == acs_pkg::ACS_WAKE && cnt_q == '0)
		else $error("wake not restarted");
endmodule

// file: testbench/acs_core_model.sv
// Behavioural stand-in for the analog converter core
module acs_core_model (
	input wire logic clk,
	input wire acs_pkg::acs_analog_t ctl,
	input wire logic [9:0] level,
	output logic [9:0] sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] noise_q = 10'h155;

	// Outside a conversion the filter output means nothing, so it never holds still
	always_ff @(posedge clk) begin
		noise_q <= ~noise_q ^ 10'h001;
	end

	// Only a powered, converting core shows the settled level
	assign sample = (ctl.powered && ctl.converting) ? level : noise_q;
endmodule

// file: testbench/testbench.sv
// Register-level bench for the conversion sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 300;
	localparam logic [15:0] A_CTL = 16'h3dc0;
	localparam logic [15:0] A_HI = 16'h3dc8;
	localparam logic [15:0] A_LO = 16'h3dcc;
	logic clk, rst, cyc, stb, we, ack, irq, dma_start;
	logic [15:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0] dma_sel;
	logic [9:0] level, sample;
	logic [7:0] r;
	acs_pkg::acs_analog_t actl;
	int n_errors, checks_done, n;

	acs_sequencer #(.SINGLE_CYCLES(SC)) u_acs_sequencer (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .dma_start(dma_start), .dma_input_select(dma_sel),
		.core_sample(sample), .analog_ctl(actl), .conv_irq(irq));
	acs_core_model u_acs_core_model (.clk(clk), .ctl(actl), .level(level), .sample(sample));

	// 25 MHz system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Counts, verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic cycle, then an idle cycle so the next request never lands in the same step
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin
			n_errors++;
			stop_test();
		end
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// Edges until the interrupt pulse is seen, capped so a silent design cannot hang
	// A quiet wait expects no pulse; otherwise running out is a mismatch
	task automatic wait_irq(input int lim, input bit quiet = 1'b0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (irq !== 1'b1 && n < lim);
		if (irq !== 1'b1 && !quiet) begin
			n_errors++;
			stop_test();
		end
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		{cyc, stb, we, dma_start} = 4'h0;
		adr = 16'h0;
		wdat = 32'h0;
		dma_sel = 4'h0;
		level = 10'h2b5;
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wb(0, A_CTL, 8'h00);
		chk(r, 8'h20);
		chk(actl, 7'h00);
		$display("test reset done");
		wb(1, A_CTL, 8'h83);
		wait_irq(SC + 100);
		chk(n, SC + 40);
		wb(0, A_HI, 8'h00);
		chk(r, 8'had);
		wb(0, A_LO, 8'h00);
		chk(r[7:6], 2'h1);
		wb(0, A_CTL, 8'h00);
		chk(r, 8'h03);
		chk(actl, 7'h53);
		$display("test single from off done");
		wb(1, A_CTL, 8'ha7);
		wb(0, A_CTL, 8'h00);
		chk(r, 8'ha7);
		chk(actl, 7'h67);
		wb(1, A_CTL, 8'h27);
		wb(0, A_CTL, 8'h00);
		chk(r, 8'ha7);
		wb(1, A_CTL, 8'ha7);
		wait_irq(SC + 100);
		chk(n, SC);
		wb(1, A_CTL, 8'h2c);
		wb(0, A_CTL, 8'h00);
		chk(r, 8'h27);
		wb(0, 16'h3de0, 8'h00);
		chk(r, 8'h00);
		repeat (120) @(posedge clk);
		chk(actl.powered, 1'b1);
		repeat (60) @(posedge clk);
		chk(actl.powered, 1'b0);
		$display("test restart and power-down done");
		// DMA start straight from power-down pays the wake cycles too
		level <= 10'h0f2;
		dma_sel <= 4'h5;
		dma_start <= 1'b1;
		@(posedge clk);
		dma_start <= 1'b0;
		wait_irq(SC + 100);
		chk(n, SC + 41);
		chk(actl.input_select, 4'h5);
		$display("test dma done");
		wb(1, A_CTL, 8'h96);
		wait_irq(SC + 100);
		chk(n, SC);
		wb(0, A_HI, 8'h00);
		chk(r, 8'h3c);
		level <= 10'h1c5;
		wait_irq(300);
		wait_irq(300);
		chk(n, 256);
		wb(0, A_LO, 8'h00);
		chk(r[7:6], 2'h2);
		wb(0, A_HI, 8'h00);
		chk(r, 8'h71);
		wb(0, A_CTL, 8'h00);
		chk(r, 8'h16);
		wb(1, A_CTL, 8'h06);
		wait_irq(300);
		wait_irq(600, 1'b1);
		chk(n, 600);
		chk(irq, 1'b0);
		$display("test repeat done");
		stop_test();
	end
endmodule
